// file: src/gate_pkg.sv
package gate_pkg;

    // System control base, kept for reference by software models.
    localparam logic [31:0] sysctl_base = 32'h400FE000;
    // Byte offsets of the registers on the plain register port.
    localparam logic [11:0] off_deep_gate = 12'h128;
    localparam logic [11:0] off_run_gate = 12'h108;
    localparam logic [11:0] off_sleep_gate = 12'h118;
    localparam logic [11:0] off_run_config = 12'h060;
    localparam logic [11:0] off_power_mode = 12'h140;
    localparam logic [11:0] off_fault = 12'h144;
    // Field positions in the gating registers.
    localparam int pos_phy = 30;
    localparam int pos_mac = 28;
    localparam int pos_port_a = 0;
    localparam int num_ports = 7;
    // Automatic gating select position in the run clock configuration.
    localparam int pos_auto_gating = 27;
    // Writable bits of a gating register; everything else reads zero.
    localparam logic [31:0] gate_mask = 32'h5000007F;
    localparam logic [31:0] gate_reset = 32'h00000000;
    localparam logic [31:0] config_reset = 32'h00000000;
    localparam int num_units = 9;

    // Power modes.
    typedef enum logic [2:0] {
        mode_run = 3'h1,
        mode_sleep = 3'h2,
        mode_deep = 3'h4
    } power_mode_type;

endpackage

// file: src/gate_select.sv
// Picks one unit's effective clock enable from the three gating sets.
module gate_select (
    input wire logic run_bit,
    input wire logic sleep_bit,
    input wire logic deep_bit,
    input wire logic auto_gating,
    input wire gate_pkg::power_mode_type mode,
    output logic enable
);

    // Sleep sets only apply when automatic gating is selected.
    always_comb begin
        enable = run_bit;
        if (auto_gating && mode == gate_pkg::mode_deep) begin
            enable = deep_bit;
        end else if (auto_gating && mode == gate_pkg::mode_sleep) begin
            enable = sleep_bit;
        end
    end

endmodule

// file: src/deep_gate_ctrl.sv
// Added by the designer: the plain strobed port.
module deep_gate_ctrl (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic unit_access,
    input wire logic [3:0] unit_select,
    output logic unit_fault,
    output logic [8:0] unit_clock_enable
);

    // The three gating sets and the run clock configuration.
    logic [31:0] deep_gate_reg_two;
    logic [31:0] sleep_gate_reg_two;
    logic [31:0] run_gate_reg_two;
    logic [31:0] run_clock_config;
    // Current power mode, written by software in this model.
    gate_pkg::power_mode_type mode;
    // Sticky record of every faulting unit, one bit each, for software to inspect.
    logic [31:0] fault_status;
    // Select of the access that produced the pending fault, one cycle late.
    logic [3:0] unit_select_q;
    // Effective enables before the output flop.
    logic [8:0] next_enable;
    logic [8:0] run_vec;
    logic [8:0] sleep_vec;
    logic [8:0] deep_vec;
    logic auto_gating_select;

    assign auto_gating_select = run_clock_config[gate_pkg::pos_auto_gating];

    // Pack the nine unit bits: ports A..G, then MAC, then PHY.
    function automatic logic [8:0] pack_units(input logic [31:0] r);
        pack_units = {r[gate_pkg::pos_phy], r[gate_pkg::pos_mac],
                      r[gate_pkg::pos_port_a +: gate_pkg::num_ports]};
    endfunction

    assign run_vec = pack_units(run_gate_reg_two);
    assign sleep_vec = pack_units(sleep_gate_reg_two);
    assign deep_vec = pack_units(deep_gate_reg_two);

    // One selector per unit keeps the three sets independent.
    for (genvar i = 0; i < gate_pkg::num_units; i++) begin : g_unit
        gate_select u_sel (
            .run_bit(run_vec[i]),
            .sleep_bit(sleep_vec[i]),
            .deep_bit(deep_vec[i]),
            .auto_gating(auto_gating_select),
            .mode(mode),
            .enable(next_enable[i])
        );
    end

    // Deep-sleep gating register; reserved bits are masked so they never store.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            deep_gate_reg_two <= gate_pkg::gate_reset;
        end else if (reg_write && reg_addr == gate_pkg::off_deep_gate) begin
            deep_gate_reg_two <= reg_wdata & gate_pkg::gate_mask;
        end
    end

    // Sleep gating register.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sleep_gate_reg_two <= gate_pkg::gate_reset;
        end else if (reg_write && reg_addr == gate_pkg::off_sleep_gate) begin
            sleep_gate_reg_two <= reg_wdata & gate_pkg::gate_mask;
        end
    end

    // Run gating register.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_gate_reg_two <= gate_pkg::gate_reset;
        end else if (reg_write && reg_addr == gate_pkg::off_run_gate) begin
            run_gate_reg_two <= reg_wdata & gate_pkg::gate_mask;
        end
    end

    // Run clock configuration; only the automatic gating select is kept.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_clock_config <= gate_pkg::config_reset;
        end else if (reg_write && reg_addr == gate_pkg::off_run_config) begin
            run_clock_config <= '0;
            run_clock_config[gate_pkg::pos_auto_gating] <=
                reg_wdata[gate_pkg::pos_auto_gating];
        end
    end

    // Power mode register stands in for the processor's sleep signals.
    // Illegal codes are ignored so the mode stays one-hot.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode <= gate_pkg::mode_run;
        end else if (reg_write && reg_addr == gate_pkg::off_power_mode) begin
            unique case (reg_wdata[2:0])
                3'h1: mode <= gate_pkg::mode_run;
                3'h2: mode <= gate_pkg::mode_sleep;
                3'h4: mode <= gate_pkg::mode_deep;
                default: mode <= mode;
            endcase
        end
    end

    // Registered enables; a zero leaves the unit unclocked.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unit_clock_enable <= '0;
        end else begin
            unit_clock_enable <= next_enable;
        end
    end

    // Enables padded to sixteen entries, so every select code indexes a real bit.
    logic [15:0] enable_lookup;
    assign enable_lookup = {7'h00, unit_clock_enable};

    // Access to a unit whose clock is off faults one cycle later.
    // Select codes above eight name no unit and never fault.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unit_fault <= 1'b0;
        end else begin
            unit_fault <= unit_access
                          && unit_select < 4'(gate_pkg::num_units)
                          && !enable_lookup[unit_select];
        end
    end

    // Fault status: sticky bit per unit, cleared by writing ones.
    // A new fault in the same cycle as its clear wins.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_status <= 32'h00000000;
        end else begin
            if (reg_write && reg_addr == gate_pkg::off_fault) begin
                fault_status <= fault_status & ~reg_wdata;
            end
            if (unit_fault) begin
                fault_status[unit_select_q] <= 1'b1;
            end
        end
    end

    // Remember which unit the fault belongs to.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unit_select_q <= 4'h0;
        end else begin
            unit_select_q <= unit_select;
        end
    end

    // Read data lands one cycle after the strobe, zero otherwise.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            unique case (reg_addr)
                gate_pkg::off_deep_gate: reg_rdata <= deep_gate_reg_two;
                gate_pkg::off_sleep_gate: reg_rdata <= sleep_gate_reg_two;
                gate_pkg::off_run_gate: reg_rdata <= run_gate_reg_two;
                gate_pkg::off_run_config: reg_rdata <= run_clock_config;
                gate_pkg::off_power_mode: reg_rdata <= {29'h0, mode};
                gate_pkg::off_fault: reg_rdata <= fault_status;
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Checks of the guarded behaviour. The enable checks name the register bits by
    // position, so a slip in the packing function shows up here and not in the field.

    // The gating register must come out of reset with every unit unclocked.
    property p_reset_zero;
        @(posedge mclk) $rose(resetn) |-> deep_gate_reg_two == gate_pkg::gate_reset;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("gate not zero");

    // The enables themselves are also dark on the first edge after reset.
    property p_enable_reset;
        @(posedge mclk) $rose(resetn) |-> unit_clock_enable == 9'h000;
    endproperty
    a_enable_reset: assert property (p_enable_reset) else $error("enable not zero");

    // A write at the decoded offset stores the writable bits on the next edge.
    property p_write_store;
        @(posedge mclk) disable iff (!resetn)
        reg_write && reg_addr == gate_pkg::off_deep_gate
            |=> deep_gate_reg_two == ($past(reg_wdata) & gate_pkg::gate_mask);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write lost");

    // Writes to any other offset leave the deep-sleep set alone.
    property p_hold;
        @(posedge mclk) disable iff (!resetn)
        !(reg_write && reg_addr == gate_pkg::off_deep_gate) |=> $stable(deep_gate_reg_two);
    endproperty
    a_hold: assert property (p_hold) else $error("deep gate changed without write");

    // Reserved bits can never hold a one.
    property p_reserved_zero;
        @(posedge mclk) disable iff (!resetn)
        (deep_gate_reg_two & ~gate_pkg::gate_mask) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

    // Read data carry the stored value in the cycle after the strobe.
    property p_read_back;
        @(posedge mclk) disable iff (!resetn)
        reg_read && reg_addr == gate_pkg::off_deep_gate && !reg_write
            |=> reg_rdata == $past(deep_gate_reg_two);
    endproperty
    a_read_back: assert property (p_read_back) else $error("bad readback");

    // In automatic deep-sleep the MAC enable follows its deep-sleep bit.
    property p_deep_apply;
        @(posedge mclk) disable iff (!resetn)
        mode == gate_pkg::mode_deep && auto_gating_select
            |=> unit_clock_enable[7] == $past(deep_gate_reg_two[28]);
    endproperty
    a_deep_apply: assert property (p_deep_apply) else $error("deep set not used");

    // In automatic deep-sleep every enable sits at its own field position.
    property p_deep_fields;
        @(posedge mclk) disable iff (!resetn)
        mode == gate_pkg::mode_deep && auto_gating_select
            |=> unit_clock_enable == $past({deep_gate_reg_two[30], deep_gate_reg_two[28],
                                            deep_gate_reg_two[6:0]});
    endproperty
    a_deep_fields: assert property (p_deep_fields) else $error("deep field misplaced");

    // Without automatic gating the PHY enable follows its run bit whatever the mode.
    property p_run_apply;
        @(posedge mclk) disable iff (!resetn)
        !auto_gating_select |=> unit_clock_enable[8] == $past(run_gate_reg_two[30]);
    endproperty
    a_run_apply: assert property (p_run_apply) else $error("run set not used");

    // In automatic sleep the port A enable follows its sleep bit.
    property p_sleep_apply;
        @(posedge mclk) disable iff (!resetn)
        mode == gate_pkg::mode_sleep && auto_gating_select
            |=> unit_clock_enable[0] == $past(sleep_gate_reg_two[0]);
    endproperty
    a_sleep_apply: assert property (p_sleep_apply) else $error("sleep set not used");

    // The mode register only ever holds one legal one-hot code.
    property p_mode_legal;
        @(posedge mclk) disable iff (!resetn) $onehot(mode);
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("mode not one-hot");

    // Only the automatic gating select is ever stored in the configuration.
    property p_config_bits;
        @(posedge mclk) disable iff (!resetn)
        (run_clock_config & ~(32'h00000001 << gate_pkg::pos_auto_gating)) == 32'h00000000;
    endproperty
    a_config_bits: assert property (p_config_bits) else $error("config bit stored");

    // An access to an unclocked port faults on the next edge.
    property p_fault;
        @(posedge mclk) disable iff (!resetn)
        unit_access && unit_select == 4'h2 && !unit_clock_enable[2] |=> unit_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("no fault");

    // An access to a clocked port completes normally.
    property p_no_fault;
        @(posedge mclk) disable iff (!resetn)
        unit_access && unit_select == 4'h2 && unit_clock_enable[2] |=> !unit_fault;
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("spurious fault");

    // Select codes beyond the last unit never fault.
    property p_no_unit;
        @(posedge mclk) disable iff (!resetn)
        unit_access && unit_select >= 4'(gate_pkg::num_units) |=> !unit_fault;
    endproperty
    a_no_unit: assert property (p_no_unit) else $error("fault for missing unit");

    // Every fault leaves its unit's bit in the status register, even beside a clear.
    property p_fault_record;
        @(posedge mclk) disable iff (!resetn)
        unit_fault |=> fault_status[$past(unit_select_q)];
    endproperty
    a_fault_record: assert property (p_fault_record) else $error("fault not recorded");

    // Main scenarios: a fault, each automatic set in use, a read, a set beside a clear.
    c_fault: cover property (@(posedge mclk) disable iff (!resetn) unit_fault);
    c_deep: cover property (@(posedge mclk) disable iff (!resetn)
        mode == gate_pkg::mode_deep && auto_gating_select && |deep_gate_reg_two);
    c_read: cover property (@(posedge mclk) disable iff (!resetn)
        reg_read && reg_addr == gate_pkg::off_deep_gate);
    c_sleep: cover property (@(posedge mclk) disable iff (!resetn)
        mode == gate_pkg::mode_sleep && auto_gating_select);
    c_set_clear: cover property (@(posedge mclk) disable iff (!resetn)
        unit_fault && reg_write && reg_addr == gate_pkg::off_fault);

endmodule

// file: sim/tb.sv
// Self-checking bench for the deep-sleep clock gating block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk;
    logic resetn;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [31:0] reg_rdata;
    logic unit_access;
    logic [3:0] unit_select;
    logic unit_fault;
    logic [8:0] unit_clock_enable;
    // Counters for the closing report and the hang guard.
    int miscompares;
    int n_tests;
    int cycles = 0;

    deep_gate_ctrl DUT (
        .mclk(mclk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .unit_access(unit_access),
        .unit_select(unit_select),
        .unit_fault(unit_fault),
        .unit_clock_enable(unit_clock_enable)
    );

    // The clock runs at 200 MHz.
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // The whole sequence takes under two hundred cycles, so this only trips on a hang.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    // Compares with case equality so an unknown never passes.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask

    // One-cycle write strobe beside address and data.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_write <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'h0;
    endtask

    // Read data are only valid in the cycle after the strobe, so sample there.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        @(posedge mclk);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'h0;
        #1;
        chk(nm, exp, reg_rdata);
    endtask

    // A one-cycle access to a unit; the fault answer stands one cycle later.
    task automatic acc(input logic [3:0] u, input logic exp);
        @(posedge mclk);
        unit_access <= 1'h1;
        unit_select <= u;
        @(posedge mclk);
        unit_access <= 1'h0;
        #1;
        chk("unit_fault", {31'h0, exp}, {31'h0, unit_fault});
    endtask

    // Sets the auto gating select and power mode, lets enables settle, checks them.
    task automatic sets(input logic [31:0] cfg, input logic [31:0] md, input logic [8:0] exp);
        wr(gate_pkg::off_run_config, cfg);
        wr(gate_pkg::off_power_mode, md);
        repeat (2) @(posedge mclk);
        #1;
        chk("unit_clock_enable", {23'h0, exp}, {23'h0, unit_clock_enable});
    endtask

    // Places a unit vector at its register bit positions.
    function automatic logic [31:0] to_reg(input logic [8:0] v);
        return {1'h0, v[8], 1'h0, v[7], 21'h0, v[6:0]};
    endfunction

    initial begin
        resetn = 1'h0;
        reg_addr = 12'h000;
        reg_wdata = 32'h00000000;
        reg_write = 1'h0;
        reg_read = 1'h0;
        unit_access = 1'h0;
        unit_select = 4'h0;
        miscompares = 0;
        n_tests = 0;
        repeat (4) @(posedge mclk);
        resetn <= 1'h1;
        #1;
        chk("enable after reset", 32'h0, {23'h0, unit_clock_enable});
        rd(gate_pkg::off_deep_gate, 32'h00000000, "deep gate");
        rd(gate_pkg::off_run_gate, 32'h00000000, "run gate");
        rd(gate_pkg::off_sleep_gate, 32'h00000000, "sleep gate");
        $display("Test reset values done");
        // Only the nine gate bits may stick; an unmapped address reads zero.
        wr(gate_pkg::off_deep_gate, 32'hFFFFFFFF);
        rd(gate_pkg::off_deep_gate, 32'h5000007F, "deep gate mask");
        rd(12'h3FC, 32'h00000000, "unmapped");
        $display("Test reserved bits done");
        // Walks a single enable across all nine units in automatic deep-sleep.
        wr(gate_pkg::off_run_gate, 32'h00000000);
        for (int i = 0; i < 9; i++) begin
            wr(gate_pkg::off_deep_gate, to_reg(9'h001 << i));
            sets(32'h08000000, 32'h00000004, 9'h001 << i);
            acc(i[3:0], 1'h0);
            acc(4'((i + 1) % 9), 1'h1);
        end
        $display("Test unit walk done");
        // Sleep and deep-sleep sets govern only in their own mode with auto gating on; otherwise the run set.
        wr(gate_pkg::off_run_gate, 32'h00000001);
        wr(gate_pkg::off_sleep_gate, 32'h00000002);
        wr(gate_pkg::off_deep_gate, 32'h10000000);
        sets(32'h08000000, 32'h00000002, 9'h002);
        sets(32'h08000000, 32'h00000004, 9'h080);
        sets(32'h08000000, 32'h00000001, 9'h001);
        sets(32'h00000000, 32'h00000004, 9'h001);
        sets(32'h00000000, 32'h00000002, 9'h001);
        // An illegal mode code leaves sleep in place; only the select bit is stored.
        wr(gate_pkg::off_power_mode, 32'h00000003);
        rd(gate_pkg::off_power_mode, 32'h00000002, "illegal mode ignored");
        wr(gate_pkg::off_run_config, 32'hFFFFFFFF);
        rd(gate_pkg::off_run_config, 32'h08000000, "config mask");
        wr(gate_pkg::off_run_config, 32'h00000000);
        $display("Test set selection done");
        // Fault status gathers one bit per refused unit and clears on a write of one.
        wr(gate_pkg::off_fault, 32'hFFFFFFFF);
        rd(gate_pkg::off_fault, 32'h00000000, "fault cleared");
        acc(4'h2, 1'h1);
        acc(4'h0, 1'h0);
        acc(4'hF, 1'h0);
        rd(gate_pkg::off_fault, 32'h00000004, "fault status");
        $display("Test fault status done");
        // A reset in mid-run must drop every gate again.
        @(posedge mclk);
        resetn <= 1'h0;
        @(posedge mclk);
        #1;
        chk("enable in reset", 32'h0, {23'h0, unit_clock_enable});
        @(posedge mclk);
        resetn <= 1'h1;
        rd(gate_pkg::off_run_gate, 32'h00000000, "run gate again");
        rd(gate_pkg::off_deep_gate, 32'h00000000, "deep gate again");
        $display("Test second reset done");
        end_of_test();
    end
endmodule
